//--- pev_pkg.sv
package pev_pkg;

  localparam logic [7:0]         OP_SINGLE   = 8'h55;
  localparam logic [7:0]         OP_DOUBLE   = 8'h75;
  localparam logic [15:0]        MAX_DEG     = 16'h001F;
  localparam logic signed [11:0] EXP_BIAS    = 12'sh080;
  localparam logic signed [11:0] EXP_MAX     = 12'sh0FF;
  localparam logic signed [11:0] EXP_MIN     = 12'sh001;
  localparam logic [31:0]        STEP_F      = 32'h0000_0004;
  localparam logic [31:0]        STEP_D      = 32'h0000_0008;
  localparam logic [31:0]        MINUS_ZERO  = 32'h0000_8000;
  localparam logic [67:0]        RND_D       = 68'h0_0000_0000_0000_0400;
  localparam logic [67:0]        RND_F       = 68'h0_0000_0400_0000_0000;
  localparam int                 SIGN_POS    = 15;
  localparam int                 F_LOW_W     = 32;
  localparam int                 PROD_F_CUT  = 33;
  localparam int                 SUM_TOP     = 66;

  typedef enum logic [0:0] {S_IDLE, S_FETCH} pev_state_t;

  typedef struct packed {
    logic       sign;
    logic [7:0] exp;
    logic [55:0] mant;
  } pev_unp_t;

  typedef struct packed {
    pev_unp_t v;
    logic     ovf;
    logic     unf;
  } pev_fma_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [63:0] arg;
    logic [15:0] degree;
    logic [31:0] tbladdr;
    logic        first_part_done_flag;
    logic [63:0] part_res;
    logic [4:0]  part_cnt;
  } pev_cmd_t;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } pev_cc_t;

  typedef struct packed {
    logic [31:0] general_reg_zero;
    logic [31:0] general_reg_one;
    logic [31:0] general_reg_two;
    logic [31:0] general_reg_three;
    logic [31:0] general_reg_four;
    logic [31:0] general_reg_five;
  } pev_regs_t;

  typedef struct packed {
    pev_state_t st;
    logic       dbl;
    logic       first;
    logic       unf;
    pev_unp_t   x;
    pev_unp_t   res;
    logic [4:0] cnt;
    logic [4:0] deg;
    logic [31:0] base;
    logic [31:0] addr;
    logic       done;
    logic       rsvd;
    logic       ovf;
    logic       unft;
    logic       first_part_done_flag;
    pev_cc_t    cc;
    pev_regs_t  regs;
  } pev_q_t;

endpackage

//--- pev_unit.sv
// Contract
// - Opcode 55 hex runs the single variant, 75 hex the double variant.
// - First coefficient at table address is highest order; lower ones follow upward.
// - Coefficients use the same floating format as the argument.
// - Result starts as top coefficient, then degree times multiply by argument, add next.
// - Degree is unsigned and names the highest numbered coefficient used.
// - Product keeps 31 or 63 fraction bits unrounded into the following add.
// - Normalise, round and range check once per iteration, after the add.
// - Degree zero returns the sole coefficient unchanged with no iterations.
// - Degree above 31 raises a reserved operand fault instead of evaluating.
// - Single end: reg0 result, reg1 and reg2 zero, reg3 table+deg*4+4.
// - Double end: reg0/1 result halves, reg2/4/5 zero, reg3 table+deg*8+8.
// - Fault with resume flag clear: bad degree, argument or coefficient.
// - Fault with resume flag set: bad coefficient, reg3 points at it.
// - Fault state lets the instruction resume once the operand is replaced.
// - Underflow after rounding zeroes the partial result, is recorded, loop goes on.
// - Recorded underflow raises an underflow trap when the instruction ends.
// - Overflow after rounding stops the instruction and raises an overflow trap.
// - On overflow reg0 holds minus zero and reg1 holds zero.
// - Overflow and underflow together: only the overflow trap, underflow dropped.
// - Zero argument with a bad coefficient may or may not fault.
`timescale 1ns/1ps
module pev_unit
  import pev_pkg::*;
(
  input  wire logic      i_clk,
  input  wire logic      i_arst_n,
  input  wire logic      i_start,
  input  wire pev_cmd_t  i_cmd,
  output logic           o_busy,
  output logic           o_mem_req,
  output logic [31:0]    o_mem_addr,
  output logic           o_mem_quad,
  input  wire logic      i_mem_ack,
  input  wire logic [63:0] i_mem_data,
  output logic           o_done,
  output logic           o_rsvd_fault,
  output logic           o_ovf_trap,
  output logic           o_unf_trap,
  output logic           o_fpd,
  output pev_cc_t        o_cc,
  output pev_regs_t      o_regs
);

  // Memory order: low word holds sign, exponent and top fraction bits
  function automatic pev_unp_t unpack(logic [63:0] w, logic dbl);
    pev_unp_t u;
    u.sign = w[SIGN_POS];
    u.exp  = w[14:7];
    u.mant = {1'b1, w[6:0], w[31:16], w[47:32], w[63:48]};
    if (!dbl) begin
      u.mant[F_LOW_W-1:0] = '0;
    end
    if (u.exp == '0) begin
      u.mant = '0;
      u.sign = 1'b0;
    end
    return u;
  endfunction

  function automatic logic [63:0] pack(pev_unp_t u, logic dbl);
    logic [63:0] w;
    w = {u.mant[15:0], u.mant[31:16], u.mant[47:32], u.sign, u.exp, u.mant[54:48]};
    if (!dbl) begin
      w[63:32] = '0;
    end
    return w;
  endfunction

  function automatic logic is_rsvd(logic [63:0] w);
    return w[SIGN_POS] && (w[14:7] == '0);
  endfunction

  function automatic pev_fma_t mul_add(pev_unp_t x, pev_unp_t r, pev_unp_t c, logic dbl);
    logic [111:0] p;
    logic [65:0]  a;
    logic [65:0]  b;
    logic [65:0]  t;
    logic [67:0]  s;
    logic signed [11:0] ea;
    logic signed [11:0] eb;
    logic signed [11:0] te;
    logic         sa;
    logic         sb;
    logic         ts;
    logic [11:0]  sh;
    int           lz;
    pev_fma_t     o;
    o  = '0;
    p  = x.mant * r.mant;
    ea = $signed({4'h0, x.exp}) + $signed({4'h0, r.exp}) - EXP_BIAS;
    if (!p[111]) begin
      p  = p << 1;
      ea = ea - 12'sd1;
    end
    a = {1'b0, p[111:48], 1'b0};
    if (!dbl) begin
      a[PROD_F_CUT-1:0] = '0;
    end
    if (x.exp == '0 || r.exp == '0) begin
      a = '0;
    end
    sa = x.sign ^ r.sign;
    b  = {1'b0, c.mant, 9'h000};
    eb = $signed({4'h0, c.exp});
    sb = c.sign;
    if (a == '0) begin
      o.v = c;
      return o;
    end
    if (b != '0 && eb > ea) begin
      t  = a;
      a  = b;
      b  = t;
      te = ea;
      ea = eb;
      eb = te;
      ts = sa;
      sa = sb;
      sb = ts;
    end
    sh = 12'(ea - eb);
    b  = (sh > 12'd65) ? '0 : (b >> sh);
    if (b > a) begin
      t  = a;
      a  = b;
      b  = t;
      ts = sa;
      sa = sb;
      sb = ts;
    end
    s = (sa == sb) ? ({2'b00, a} + {2'b00, b}) : ({2'b00, a} - {2'b00, b});
    if (s == '0) begin
      return o;
    end
    // Single normalise and round for the fused step
    lz = 0;
    for (int i = 0; i <= SUM_TOP; i++) begin
      if (s[i]) begin
        lz = SUM_TOP - i;
      end
    end
    s  = s << lz;
    // Hidden bit of the aligned sum sits two places below the normalised top
    te = ea + 12'sd2 - 12'(lz);
    s  = s + (dbl ? RND_D : RND_F);
    if (s[67]) begin
      s  = s >> 1;
      te = te + 12'sd1;
    end
    o.v.sign = sa;
    o.v.exp  = te[7:0];
    o.v.mant = s[66:11];
    if (!dbl) begin
      o.v.mant[F_LOW_W-1:0] = '0;
    end
    o.ovf = te > EXP_MAX;
    o.unf = te < EXP_MIN;
    return o;
  endfunction

  pev_q_t q;
  pev_q_t d;
  pev_unp_t coef;
  pev_unp_t nres;
  pev_fma_t f;
  logic [31:0] step;
  logic [63:0] pk;
  logic        fin;
  logic        ok_op;

  assign ok_op = (i_cmd.opcode == OP_SINGLE) || (i_cmd.opcode == OP_DOUBLE);
  assign step  = q.dbl ? STEP_D : STEP_F;
  assign coef  = unpack(i_mem_data, q.dbl);
  assign f     = mul_add(q.x, q.res, coef, q.dbl);

  always_comb begin
    d      = q;
    nres   = q.res;
    fin    = 1'b0;
    pk     = '0;
    d.done = 1'b0;
    d.rsvd = 1'b0;
    d.ovf  = 1'b0;
    d.unft = 1'b0;
    unique case (q.st)
      S_IDLE: begin
        if (i_start && ok_op) begin
          d.dbl = (i_cmd.opcode == OP_DOUBLE);
          d.x   = unpack(i_cmd.arg, i_cmd.opcode == OP_DOUBLE);
          d.unf = 1'b0;
          d.first_part_done_flag = i_cmd.first_part_done_flag;
          if (i_cmd.first_part_done_flag) begin
            // Resume from the saved partial state
            d.res   = unpack(i_cmd.part_res, i_cmd.opcode == OP_DOUBLE);
            d.cnt   = i_cmd.part_cnt;
            d.deg   = i_cmd.part_cnt;
            d.addr  = i_cmd.tbladdr;
            d.base  = i_cmd.tbladdr - ((i_cmd.opcode == OP_DOUBLE) ? STEP_D : STEP_F);
            d.first = 1'b0;
            d.st    = S_FETCH;
          end else if (i_cmd.degree > MAX_DEG || is_rsvd(i_cmd.arg)) begin
            d.rsvd = 1'b1;
            d.first_part_done_flag  = 1'b0;
          end else begin
            d.cnt   = i_cmd.degree[4:0];
            d.deg   = i_cmd.degree[4:0];
            d.base  = i_cmd.tbladdr;
            d.addr  = i_cmd.tbladdr;
            d.first = 1'b1;
            d.st    = S_FETCH;
          end
        end
      end
      S_FETCH: begin
        if (i_mem_ack) begin
          if (is_rsvd(i_mem_data)) begin
            pk     = pack(q.res, q.dbl);
            d.rsvd = 1'b1;
            d.first_part_done_flag  = !q.first;
            d.regs.general_reg_zero  = pk[31:0];
            d.regs.general_reg_one   = pk[63:32];
            d.regs.general_reg_two   = {27'h0, q.cnt};
            d.regs.general_reg_three = q.addr;
            d.st   = S_IDLE;
          end else begin
            d.addr = q.addr + step;
            if (q.first) begin
              d.res   = coef;
              nres    = coef;
              d.first = 1'b0;
              fin     = (q.cnt == '0);
            end else if (f.ovf) begin
              d.ovf  = 1'b1;
              d.unf  = 1'b0;
              d.first_part_done_flag  = 1'b0;
              d.regs.general_reg_zero = MINUS_ZERO;
              d.regs.general_reg_one  = '0;
              d.cc   = '{n: 1'b1, z: 1'b0, v: 1'b1, c: 1'b0};
              d.st   = S_IDLE;
            end else begin
              nres  = f.unf ? pev_unp_t'('0) : f.v;
              d.res = nres;
              d.unf = q.unf | f.unf;
              d.cnt = q.cnt - 5'd1;
              fin   = (q.cnt == 5'd1);
            end
          end
        end
      end
    endcase
    if (fin) begin
      pk     = pack(nres, q.dbl);
      d.st   = S_IDLE;
      d.done = 1'b1;
      d.unft = d.unf;
      d.first_part_done_flag  = 1'b0;
      d.regs.general_reg_zero  = pk[31:0];
      d.regs.general_reg_one   = q.dbl ? pk[63:32] : '0;
      d.regs.general_reg_two   = '0;
      d.regs.general_reg_three = d.addr;
      d.regs.general_reg_four  = '0;
      d.regs.general_reg_five  = '0;
      d.cc = '{n: nres.sign, z: (nres.exp == '0), v: 1'b0, c: 1'b0};
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_busy       = (q.st != S_IDLE);
  assign o_mem_req    = (q.st == S_FETCH);
  assign o_mem_addr   = q.addr;
  assign o_mem_quad   = q.dbl;
  assign o_done       = q.done;
  assign o_rsvd_fault = q.rsvd;
  assign o_ovf_trap   = q.ovf;
  assign o_unf_trap   = q.unft;
  assign o_fpd        = q.first_part_done_flag;
  assign o_cc         = q.cc;
  assign o_regs       = q.regs;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  sequence s_new_start;
    q.st == S_IDLE && i_start && ok_op && !i_cmd.first_part_done_flag;
  endsequence

  sequence s_mid_ack;
    o_mem_req && i_mem_ack && !is_rsvd(i_mem_data) && !q.first && !f.ovf && q.cnt > 5'd1;
  endsequence

  property p_opc_double;
    s_new_start and (i_cmd.opcode == OP_DOUBLE) and (i_cmd.degree <= MAX_DEG)
      and !is_rsvd(i_cmd.arg) |=> o_mem_req && o_mem_quad;
  endproperty
  a_opc_double: assert property (p_opc_double) else $error("double opcode not taken");

  property p_deg_fault;
    s_new_start and (i_cmd.degree > MAX_DEG) |=> o_rsvd_fault && !o_fpd && !o_mem_req;
  endproperty
  a_deg_fault: assert property (p_deg_fault) else $error("large degree not faulted");

  property p_addr_walk;
    s_mid_ack |=> o_mem_req && o_mem_addr == $past(o_mem_addr) + step;
  endproperty
  a_addr_walk: assert property (p_addr_walk) else $error("coefficient address wrong");

  property p_deg_zero;
    o_mem_req && i_mem_ack && q.first && q.cnt == '0 && !q.dbl && !is_rsvd(i_mem_data)
      |=> o_done && o_regs.general_reg_zero == $past(i_mem_data[31:0]);
  endproperty
  a_deg_zero: assert property (p_deg_zero) else $error("degree zero result wrong");

  property p_end_addr;
    o_done |-> o_regs.general_reg_three == q.base + 32'(q.deg) * step + step
      && o_regs.general_reg_two == '0;
  endproperty
  a_end_addr: assert property (p_end_addr) else $error("final register three wrong");

  property p_ovf_regs;
    o_ovf_trap |-> o_regs.general_reg_zero == MINUS_ZERO && o_regs.general_reg_one == '0
      && o_cc.v && $past(o_mem_req) && !o_busy;
  endproperty
  a_ovf_regs: assert property (p_ovf_regs) else $error("overflow state wrong");

  property p_ovf_only;
    o_ovf_trap |-> !o_unf_trap && !o_done;
  endproperty
  a_ovf_only: assert property (p_ovf_only) else $error("underflow kept on overflow");

  property p_unf_end;
    o_done && q.unf |-> o_unf_trap;
  endproperty
  a_unf_end: assert property (p_unf_end) else $error("underflow trap missing");

  property p_fpd_ptr;
    o_rsvd_fault && o_fpd |-> o_regs.general_reg_three == $past(o_mem_addr);
  endproperty
  a_fpd_ptr: assert property (p_fpd_ptr) else $error("fault pointer wrong");

  property p_cc;
    o_done |-> !o_cc.c && !o_cc.v && o_cc.z == (o_regs.general_reg_zero[14:7] == '0);
  endproperty
  a_cc: assert property (p_cc) else $error("condition codes wrong");

endmodule

//--- pev_mem.sv
`timescale 1ns/1ps
module pev_mem
  import pev_pkg::*;
#(
  parameter logic [31:0] BASE = 32'h0000_1000
) (
  input  wire logic        i_clk,
  input  wire logic        i_req,
  input  wire logic [31:0] i_addr,
  input  wire logic        i_quad,
  input  wire logic [3:0]  i_lat,
  output logic             o_ack,
  output logic [63:0]      o_data
);
  logic [31:0] mem  [0:63];
  logic [31:0] alog [0:63];
  logic [3:0]  wait_q    = 4'h0;
  logic        last_quad = 1'b0;
  int          nfetch    = 0;
  logic [5:0]  idx;

  assign idx = 6'((i_addr - BASE) >> 2);

  initial begin
    o_ack = 1'b0;
    o_data = 64'h0;
  end

  // Idle data toggles every cycle so a stale word can never pass for a fresh one
  always @(posedge i_clk) begin
    if (i_req && !o_ack && wait_q >= i_lat) begin
      o_ack <= 1'b1;
      o_data <= {i_quad ? mem[idx + 6'h01] : ~o_data[63:32], mem[idx]};
      alog[6'(nfetch)] <= i_addr;
      nfetch <= nfetch + 1;
      last_quad <= i_quad;
      wait_q <= 4'h0;
    end else begin
      o_ack <= 1'b0;
      o_data <= ~o_data;
      wait_q <= (i_req && !o_ack) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule

//--- polynomial_evaluation_unit_tb.sv
`timescale 1ns/1ps
module polynomial_evaluation_unit_tb;
  import pev_pkg::*;
  localparam logic [31:0] BASE = 32'h0000_1000;
  logic        i_clk      = 1'b0;
  logic        i_arst_n   = 1'b0;
  logic        i_start    = 1'b0;
  pev_cmd_t    i_cmd      = '0;
  logic [3:0]  lat        = 4'h0;
  logic        i_mem_ack;
  logic [63:0] i_mem_data;
  logic        o_busy, o_mem_req, o_mem_quad, o_done, o_rsvd_fault, o_ovf_trap;
  logic        o_unf_trap, o_fpd;
  logic [31:0] o_mem_addr;
  pev_cc_t     o_cc;
  pev_regs_t   o_regs;
  pev_regs_t   rg;
  logic [4:0]  ev;
  logic [3:0]  cc;
  int          num_errors  = 0;
  int          check_count = 0;
  int          cyc         = 0;
  int          n0;
  int          nf;

  always #25 i_clk = ~i_clk;

  pev_unit dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_start(i_start), .i_cmd(i_cmd),
    .o_busy(o_busy), .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr),
    .o_mem_quad(o_mem_quad), .i_mem_ack(i_mem_ack), .i_mem_data(i_mem_data),
    .o_done(o_done), .o_rsvd_fault(o_rsvd_fault), .o_ovf_trap(o_ovf_trap),
    .o_unf_trap(o_unf_trap), .o_fpd(o_fpd), .o_cc(o_cc), .o_regs(o_regs));

  pev_mem #(.BASE(BASE)) far (.i_clk(i_clk), .i_req(o_mem_req), .i_addr(o_mem_addr),
    .i_quad(o_mem_quad), .i_lat(lat), .o_ack(i_mem_ack), .o_data(i_mem_data));

  task automatic report_and_stop();
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic ld(input int i, input logic [31:0] a, b, c, d);
    far.mem[i] = a;
    far.mem[i + 1] = b;
    far.mem[i + 2] = c;
    far.mem[i + 3] = d;
  endtask

  // Second start cycle (again) lands while busy and must be ignored
  task automatic run(input logic [7:0] op, input logic [63:0] x, input logic [15:0] dg,
                     input logic [31:0] tb, input logic fp, input logic [63:0] pr,
                     input logic [4:0] pc, input logic again);
    int n;
    n0 = far.nfetch;
    @(negedge i_clk);
    i_cmd = '{op, x, dg, tb, fp, pr, pc};
    i_start = 1'b1;
    @(negedge i_clk);
    i_start = again;
    n = 0;
    while (o_done !== 1'b1 && o_rsvd_fault !== 1'b1 && o_ovf_trap !== 1'b1 && n < 500) begin
      @(negedge i_clk);
      i_start = 1'b0;
      n++;
    end
    chk("finish", 64'(n < 500), 64'h1);
    ev = {o_done, o_rsvd_fault, o_ovf_trap, o_unf_trap, o_fpd};
    rg = o_regs;
    cc = o_cc;
    nf = far.nfetch - n0;
  endtask

  task automatic t_single();
    ld(0, 32'h0000_3F80, 32'h0000_4000, 32'h0000_4080, 32'h0);
    lat = 4'h2;
    run(OP_SINGLE, 64'h4100, 16'h0002, BASE, 1'b0, 64'h0, 5'h0, 1'b1);
    chk("ev", 64'(ev), 64'h10);
    chk("r1r0", {rg.general_reg_one, rg.general_reg_zero}, 64'h4140);
    chk("r2cc", 64'({rg.general_reg_two, cc}), 64'h0);
    chk("r3", 64'(rg.general_reg_three), 64'(BASE + 32'h0000_000C));
    chk("nf", 64'(nf), 64'h3);
    chk("a0", 64'(far.alog[6'(n0)]), 64'(BASE));
    chk("a2", 64'(far.alog[6'(n0 + 2)]), 64'(BASE + 32'h0000_0008));
    chk("quad", 64'(far.last_quad), 64'h0);
  endtask

  task automatic t_double();
    ld(16, 32'h0000_3F80, 32'h0, 32'h0000_4000, 32'h0);
    ld(20, 32'h0000_4080, 32'h0, 32'h0, 32'h0);
    lat = 4'h0;
    run(OP_DOUBLE, 64'h4100, 16'h0002, BASE + 32'h0000_0040, 1'b0, 64'h0, 5'h0, 1'b0);
    chk("ev", 64'(ev), 64'h10);
    chk("r1r0", {rg.general_reg_one, rg.general_reg_zero}, 64'h4140);
    chk("r24", {rg.general_reg_two, rg.general_reg_four}, 64'h0);
    chk("r5", 64'(rg.general_reg_five), 64'h0);
    chk("r3", 64'(rg.general_reg_three), 64'(BASE + 32'h0000_0058));
    chk("quad", 64'(far.last_quad), 64'h1);
  endtask

  task automatic t_deg0();
    ld(8, 32'h1234_3F80, 32'h0, 32'h0, 32'h0);
    run(OP_SINGLE, 64'h4100, 16'h0000, BASE + 32'h0000_0020, 1'b0, 64'h0, 5'h0, 1'b0);
    chk("r0", 64'(rg.general_reg_zero), 64'h1234_3F80);
    chk("r3", 64'(rg.general_reg_three), 64'(BASE + 32'h0000_0024));
    chk("nf", 64'(nf), 64'h1);
  endtask

  task automatic t_big(input logic [63:0] x, input logic [15:0] dg);
    run(OP_SINGLE, x, dg, BASE, 1'b0, 64'h0, 5'h0, 1'b0);
    chk("ev", 64'(ev), 64'h08);
    chk("nf", 64'(nf), 64'h0);
  endtask

  task automatic t_resume();
    ld(0, 32'h0000_3F80, 32'h0000_8000, 32'h0000_4080, 32'h0);
    run(OP_SINGLE, 64'h4100, 16'h0002, BASE, 1'b0, 64'h0, 5'h0, 1'b0);
    chk("ev", 64'(ev), 64'h09);
    chk("r3", 64'(rg.general_reg_three), 64'(BASE + 32'h0000_0004));
    far.mem[1] = 32'h0000_4000;
    run(OP_SINGLE, 64'h4100, 16'h0002, rg.general_reg_three, 1'b1,
        {rg.general_reg_one, rg.general_reg_zero}, rg.general_reg_two[4:0], 1'b0);
    chk("ev", 64'(ev), 64'h10);
    chk("r0", 64'(rg.general_reg_zero), 64'h4140);
    chk("r3", 64'(rg.general_reg_three), 64'(BASE + 32'h0000_000C));
  endtask

  task automatic t_ovf();
    ld(24, 32'h0000_7F80, 32'h0000_4080, 32'h0, 32'h0);
    run(OP_SINGLE, 64'h7F80, 16'h0001, BASE + 32'h0000_0060, 1'b0, 64'h0, 5'h0, 1'b0);
    chk("ev", 64'(ev), 64'h04);
    chk("r1r0", {rg.general_reg_one, rg.general_reg_zero}, 64'h8000);
    chk("cc", 64'(cc), 64'hA);
  endtask

  task automatic t_unf();
    ld(28, 32'h0000_0080, 32'h0, 32'h0000_4080, 32'h0);
    run(OP_SINGLE, 64'h0080, 16'h0002, BASE + 32'h0000_0070, 1'b0, 64'h0, 5'h0, 1'b0);
    chk("ev", 64'(ev), 64'h12);
    chk("r0", 64'(rg.general_reg_zero), 64'h4080);
  endtask

  task automatic t_both();
    ld(32, 32'h0000_0080, 32'h0, 32'hFFFF_7FFF, 32'hFFFF_7FFF);
    run(OP_SINGLE, 64'h4000, 16'h0003, BASE + 32'h0000_0080, 1'b0, 64'h0, 5'h0, 1'b0);
    chk("ev", 64'(ev), 64'h04);
  endtask

  // Zero argument with a reserved low coefficient: fault or completion both allowed
  task automatic t_zarg();
    ld(40, 32'h0000_4080, 32'h0000_8000, 32'h0, 32'h0);
    run(OP_SINGLE, 64'h0, 16'h0001, BASE + 32'h0000_00A0, 1'b0, 64'h0, 5'h0, 1'b0);
    chk("zarg", 64'(ev == 5'h09 || ev == 5'h10), 64'h1);
  endtask

  task automatic t_badop();
    @(negedge i_clk);
    i_cmd.opcode = 8'h00;
    i_start = 1'b1;
    @(negedge i_clk);
    i_start = 1'b0;
    @(negedge i_clk);
    chk("idle", 64'({o_busy, o_mem_req}), 64'h0);
  endtask

  initial begin
    repeat (20) @(negedge i_clk);
    i_arst_n = 1'b1;
    t_single();
    t_double();
    t_deg0();
    t_big(64'h4100, 16'h0020);
    t_big(64'h4100, 16'h8000);
    t_big(64'h8000, 16'h0002);
    t_resume();
    t_ovf();
    t_unf();
    t_both();
    t_zarg();
    t_badop();
    report_and_stop();
  end
endmodule
